// file: core/rmc_line_ctl.sv
// controller end: Avalon-MM registers, tone, metering timer, ring toggler
// assumes the detect wire is asynchronous to clk_sys and pulled up
`timescale 1ns/1ps
module rmc_line_ctl
   import rmc_pkg::*;
#(
   parameter int TONE_HALF_LOW  = `RMC_CLK_HZ / (2 * `RMC_TONE_LOW_HZ),
   parameter int TONE_HALF_HIGH = `RMC_CLK_HZ / (2 * `RMC_TONE_HIGH_HZ)
)
(
   input  wire logic   clk_sys,
   input  wire logic   nrst,
   input  wire logic [4:0]  avs_address,
   input  wire logic   avs_read,
   input  wire logic   avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic        avs_waitrequest,
   output logic        irq,
   rmc_line_if.ctl     line
);

   rmc_ctl_st_t r_reg;
   rmc_ctl_st_t r_next;
   logic        req;
   logic        wr_ok;
   logic [15:0] tone_half;
   logic        det_low;
   logic [`RMC_ST_W-1:0] ev;
   logic [`RMC_ST_W-1:0] clr;
   logic [1:0]  mode;

   assign req      = avs_read || avs_write;
   assign wr_ok    = avs_write && !r_reg.wait_rq;
   assign tone_half = r_reg.ctrl[`RMC_CTRL_TONE16] ? 16'(TONE_HALF_HIGH) : 16'(TONE_HALF_LOW);
   assign det_low  = !r_reg.det_s2;
   assign mode     = r_reg.ctrl[`RMC_CTRL_MODE_MSB:`RMC_CTRL_MODE_LSB];
   assign clr      = (wr_ok && (avs_address == `RMC_A_ICLR)) ?
                     avs_writedata[`RMC_ST_W-1:0] : '0;

   // next state
   always_comb
   begin
      r_next = r_reg;
      ev = '0;
      r_next.det_s1 = line.loop_detect_n;
      r_next.det_s2 = r_reg.det_s1;
      r_next.det_s3 = r_reg.det_s2; // edge memory, the first sync flop stays private

      // one wait cycle per access, then the access completes
      r_next.wait_rq = !(req && r_reg.wait_rq);
      if (req && r_reg.wait_rq)
      begin
         case (avs_address)
            `RMC_A_CTRL:  r_next.rdata = {28'h0000000, r_reg.ctrl};
            `RMC_A_METER: r_next.rdata = r_reg.met_cnt;
            `RMC_A_RING:  r_next.rdata = r_reg.ring_half;
            `RMC_A_STAT:  r_next.rdata = {29'h00000000, r_reg.st};
            `RMC_A_IEN:   r_next.rdata = {29'h00000000, r_reg.ien};
            `RMC_A_LIVE:  r_next.rdata = {26'h0000000, r_reg.cst, r_reg.det_s2,
                                          r_reg.met, r_reg.pol, r_reg.feed};
            default:      r_next.rdata = 32'h00000000;
         endcase
      end
      if (wr_ok && (avs_address == `RMC_A_CTRL))
      begin
         r_next.ctrl = avs_writedata[3:0];
      end
      if (wr_ok && (avs_address == `RMC_A_RING))
      begin
         r_next.ring_half = avs_writedata;
      end
      if (wr_ok && (avs_address == `RMC_A_IEN))
      begin
         r_next.ien = avs_writedata[`RMC_ST_W-1:0];
      end

      // free-running metering tone
      if (r_reg.tone_cnt >= tone_half - 16'h0001)
      begin
         r_next.tone_cnt = 16'h0000;
         r_next.tone = !r_reg.tone;
      end
      else
      begin
         r_next.tone_cnt = r_reg.tone_cnt + 16'h0001;
      end

      // metering burst: bit held for the written number of cycles
      if (wr_ok && (avs_address == `RMC_A_METER) && (mode == RMC_ACTIVE))
      begin
         r_next.met_cnt = avs_writedata;
      end
      else if ((mode != RMC_ACTIVE) || (r_reg.cst != RMC_C_IDLE))
      begin
         r_next.met_cnt = 32'h00000000;
      end
      else if (r_reg.met_cnt != 32'h00000000)
      begin
         r_next.met_cnt = r_reg.met_cnt - 32'h00000001;
         ev[`RMC_ST_BURST] = (r_reg.met_cnt == 32'h00000001);
      end

      // off-hook seen while feeding: falling edge of the synchronised wire
      ev[`RMC_ST_OFFHOOK] = det_low && r_reg.det_s3 &&
                            ((mode == RMC_HIZ) || (mode == RMC_ACTIVE));

      // ring sequencing
      case (r_reg.cst)
         RMC_C_IDLE:
         begin
            r_next.pol = r_reg.ctrl[`RMC_CTRL_POL];
            r_next.ring_cnt = 32'h00000000;
            if (mode == RMC_RING)
            begin
               r_next.cst = RMC_C_RING;
            end
         end
         RMC_C_RING:
         begin
            if (det_low)
            begin
               r_next.cst = RMC_C_STOP;
               ev[`RMC_ST_TRIP] = 1'b1;
            end
            else if (mode != RMC_RING)
            begin
               r_next.cst = RMC_C_IDLE;
            end
            else if (r_reg.ring_cnt >= r_reg.ring_half)
            begin
               r_next.ring_cnt = 32'h00000000;
               r_next.pol = !r_reg.pol;
            end
            else
            begin
               r_next.ring_cnt = r_reg.ring_cnt + 32'h00000001;
            end
         end
         RMC_C_STOP:
         begin
            r_next.ctrl[`RMC_CTRL_MODE_MSB:`RMC_CTRL_MODE_LSB] = RMC_ACTIVE;
            r_next.cst = RMC_C_IDLE;
         end
         default:
         begin
            r_next.cst = RMC_C_IDLE;
         end
      endcase

      // pin levels per mode
      r_next.pwr  = (mode != RMC_PDOWN);
      r_next.feed = (mode == RMC_ACTIVE) && (r_reg.cst == RMC_C_IDLE);
      // ring select only while the mode is still ring, so power down never sees it
      r_next.met  = ((r_reg.cst != RMC_C_IDLE) && (mode == RMC_RING)) ||
                    ((mode == RMC_ACTIVE) && (r_next.met_cnt != 32'h00000000));

      // sticky status, set wins over clear
      r_next.st  = (r_reg.st & ~clr) | ev;
      r_next.irq = |(r_next.st & r_reg.ien);
   end

   // state register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '0;
         r_reg.wait_rq <= 1'b1;
         r_reg.det_s1 <= 1'b1;
         r_reg.det_s2 <= 1'b1;
         r_reg.det_s3 <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign avs_readdata             = r_reg.rdata;
   assign avs_waitrequest          = r_reg.wait_rq;
   assign irq                      = r_reg.irq;
   assign line.metering_tone_clock = r_reg.tone;
   assign line.metering_enable_bit = r_reg.met;
   assign line.feed_select_bit     = r_reg.feed;
   assign line.polarity_bit        = r_reg.pol;
   assign line.power_on_select     = r_reg.pwr;

endmodule : rmc_line_ctl

// file: core/rmc_line_dev.sv
// line-side end: mode decode, soft polarity, metering envelope, detect
// assumes mode pins come from logic on clk_sys; analog senses are asynchronous
`timescale 1ns/1ps
module rmc_line_dev
   import rmc_pkg::*;
#(
   parameter logic [15:0] RAMP_STEP = `RMC_STEP_DEF,
   parameter logic [15:0] ENV_STEP  = `RMC_STEP_DEF
)
(
   input  wire logic   clk_sys,
   input  wire logic   nrst,
   rmc_line_if.dev     line,
   input  wire logic   hook_sense,
   input  wire logic   impedance_drop_sense,
   output logic [1:0]  mode_code,
   output logic        loops_disabled,
   output logic        drivers_voltage_mode,
   output logic [7:0]  line_polarity_level,
   output logic [7:0]  metering_envelope,
   output logic        shaped_metering_wave,
   output logic        metering_injection
);

   rmc_dev_st_t r_reg;
   rmc_dev_st_t r_next;
   logic        ramp_tick;
   logic        env_tick;
   logic        pol_target;
   logic        meter_gate;

   // step ticks for the two slow ramps
   assign ramp_tick = (r_reg.ramp_cnt == RAMP_STEP - 16'h0001);
   assign env_tick  = (r_reg.env_cnt == ENV_STEP - 16'h0001);
   assign pol_target = line.polarity_bit;
   assign meter_gate = (r_reg.mode == RMC_ACTIVE) && line.metering_enable_bit;

   // next state of the whole end
   always_comb
   begin
      r_next = r_reg;

      // two-flop synchronisers for the analog senses
      r_next.hook_s1 = hook_sense;
      r_next.hook_s2 = r_reg.hook_s1;
      r_next.imp_s1  = impedance_drop_sense;
      r_next.imp_s2  = r_reg.imp_s1;

      // mode decode from the parallel pins
      if (!line.power_on_select)
      begin
         r_next.mode = RMC_PDOWN;
      end
      else if (line.feed_select_bit)
      begin
         r_next.mode = RMC_ACTIVE;
      end
      else if (line.metering_enable_bit)
      begin
         r_next.mode = RMC_RING;
      end
      else
      begin
         r_next.mode = RMC_HIZ;
      end

      // ringing turns both loops off, drivers act as buffers
      r_next.loops_off = (r_next.mode == RMC_RING);

      // polarity ramp step counter
      if (ramp_tick)
      begin
         r_next.ramp_cnt = 16'h0000;
      end
      else
      begin
         r_next.ramp_cnt = r_reg.ramp_cnt + 16'h0001;
      end

      // soft polarity: move one step toward direct or reverse
      if (ramp_tick && ((r_reg.mode == RMC_ACTIVE) || (r_reg.mode == RMC_RING)))
      begin
         if (pol_target && (r_reg.pol_lvl != `RMC_LVL_MAX))
         begin
            r_next.pol_lvl = r_reg.pol_lvl + 8'h01;
         end
         else if (!pol_target && (r_reg.pol_lvl != `RMC_LVL_ZERO))
         begin
            r_next.pol_lvl = r_reg.pol_lvl - 8'h01;
         end
      end

      // envelope step counter
      if (env_tick)
      begin
         r_next.env_cnt = 16'h0000;
      end
      else
      begin
         r_next.env_cnt = r_reg.env_cnt + 16'h0001;
      end

      // burst envelope rises while enabled in active mode, decays after
      if (env_tick)
      begin
         if (meter_gate && (r_reg.env != `RMC_LVL_MAX))
         begin
            r_next.env = r_reg.env + 8'h01;
         end
         else if (!meter_gate && (r_reg.env != `RMC_LVL_ZERO))
         begin
            r_next.env = r_reg.env - 8'h01;
         end
      end
      if (r_reg.mode == RMC_PDOWN)
      begin
         r_next.env = `RMC_LVL_ZERO;
      end

      // square wave follows the tone clock while the envelope is up
      r_next.wave = line.metering_tone_clock && (r_reg.env != `RMC_LVL_ZERO);
      r_next.inj  = (r_reg.env != `RMC_LVL_ZERO);

      // loop detect: hook in feed modes, ring trip in ringing
      case (r_reg.mode)
         RMC_PDOWN:
         begin
            r_next.det_oe_n = 1'b1;
         end
         RMC_HIZ,
         RMC_ACTIVE:
         begin
            r_next.det_oe_n = !r_reg.hook_s2;
         end
         RMC_RING:
         begin
            r_next.det_oe_n = !r_reg.imp_s2;
         end
         default:
         begin
            r_next.det_oe_n = 1'b1;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '{
            mode:      RMC_PDOWN,
            hook_s1:   1'b0,
            hook_s2:   1'b0,
            imp_s1:    1'b0,
            imp_s2:    1'b0,
            pol_lvl:   `RMC_LVL_ZERO,
            ramp_cnt:  16'h0000,
            env:       `RMC_LVL_ZERO,
            env_cnt:   16'h0000,
            det_oe_n:  1'b1,
            wave:      1'b0,
            inj:       1'b0,
            loops_off: 1'b0
         };
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register
   assign mode_code            = r_reg.mode;
   assign loops_disabled       = r_reg.loops_off;
   assign drivers_voltage_mode = r_reg.loops_off;
   assign line_polarity_level  = r_reg.pol_lvl;
   assign metering_envelope    = r_reg.env;
   assign shaped_metering_wave = r_reg.wave;
   assign metering_injection   = r_reg.inj;

   // open drain: data always low, enable low pulls the wire
   assign line.loop_detect_n_o    = 1'b0;
   assign line.loop_detect_n_oe_n = r_reg.det_oe_n;

endmodule : rmc_line_dev

// file: core/rmc_line_if.sv
// parallel mode pins, metering tone and open-drain loop detect wire
// assumes an external pull-up on the detect wire
`timescale 1ns/1ps
interface rmc_line_if;
   logic metering_tone_clock;
   logic metering_enable_bit;
   logic feed_select_bit;
   logic polarity_bit;
   logic power_on_select;
   logic loop_detect_n_o;
   logic loop_detect_n_oe_n;
   logic loop_detect_n;

   // pull-up resolves the open-drain wire
   assign loop_detect_n = loop_detect_n_oe_n ? 1'b1 : loop_detect_n_o;

   modport dev (
      input  metering_tone_clock,
      input  metering_enable_bit,
      input  feed_select_bit,
      input  polarity_bit,
      input  power_on_select,
      output loop_detect_n_o,
      output loop_detect_n_oe_n
   );

   modport ctl (
      output metering_tone_clock,
      output metering_enable_bit,
      output feed_select_bit,
      output polarity_bit,
      output power_on_select,
      input  loop_detect_n
   );
endinterface : rmc_line_if

// file: core/rmc_params.svh
// named constants shared by both ends of the ring and metering link
// assumes one 200 MHz system clock on both ends and a pulled-up detect wire
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH
`define RMC_CLK_HZ       200000000
`define RMC_TONE_LOW_HZ  12000
`define RMC_TONE_HIGH_HZ 16000
`define RMC_LVL_MAX      8'hff
`define RMC_LVL_ZERO     8'h00
`define RMC_STEP_DEF     16'h0040
// register byte offsets
`define RMC_A_CTRL   5'h00
`define RMC_A_METER  5'h04
`define RMC_A_RING   5'h08
`define RMC_A_STAT   5'h0c
`define RMC_A_IEN    5'h10
`define RMC_A_ICLR   5'h14
`define RMC_A_LIVE   5'h18
// control register fields
`define RMC_CTRL_MODE_LSB 0
`define RMC_CTRL_MODE_MSB 1
`define RMC_CTRL_POL      2
`define RMC_CTRL_TONE16   3
// status and enable fields
`define RMC_ST_TRIP    0
`define RMC_ST_OFFHOOK 1
`define RMC_ST_BURST   2
`define RMC_ST_W       3
`endif

// file: core/rmc_pkg.sv
// types shared by both ends: line modes, controller states, state records
// assumes rmc_params.svh is on the include path
`include "rmc_params.svh"
package rmc_pkg;
   typedef enum logic [1:0] {
      RMC_PDOWN  = 2'b00,
      RMC_HIZ    = 2'b01,
      RMC_ACTIVE = 2'b10,
      RMC_RING   = 2'b11
   } rmc_mode_t;

   typedef enum logic [1:0] {
      RMC_C_IDLE = 2'b00,
      RMC_C_RING = 2'b01,
      RMC_C_STOP = 2'b10
   } rmc_cstate_t;

   typedef struct packed {
      rmc_mode_t   mode;
      logic        hook_s1;
      logic        hook_s2;
      logic        imp_s1;
      logic        imp_s2;
      logic [7:0]  pol_lvl;
      logic [15:0] ramp_cnt;
      logic [7:0]  env;
      logic [15:0] env_cnt;
      logic        det_oe_n;
      logic        wave;
      logic        inj;
      logic        loops_off;
   } rmc_dev_st_t;

   typedef struct packed {
      logic        wait_rq;
      logic [31:0] rdata;
      logic [3:0]  ctrl;
      logic [31:0] ring_half;
      logic [31:0] ring_cnt;
      logic [31:0] met_cnt;
      logic [`RMC_ST_W-1:0] st;
      logic [`RMC_ST_W-1:0] ien;
      logic        irq;
      logic [15:0] tone_cnt;
      logic        tone;
      logic        met;
      logic        feed;
      logic        pol;
      logic        pwr;
      logic        det_s1;
      logic        det_s2;
      logic        det_s3;
      rmc_cstate_t cst;
   } rmc_ctl_st_t;
endpackage : rmc_pkg

// file: dv/ring_and_metering_control_test.sv
// self-checking bench: both ends joined, a register model compared at every status read
// assumes core/ on the include path; tone and ramp counts shortened by parameter
`timescale 1ns/1ps
`include "rmc_params.svh"
module ring_and_metering_control_test;
   logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest, irq;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        hook_sense, impedance_drop_sense, loops_disabled, drivers_voltage_mode;
   logic        shaped_metering_wave, metering_injection;
   logic [1:0]  mode_code;
   logic [7:0]  line_polarity_level, metering_envelope, lfsr_val;
   int          bad_count, checks, m_stat, m_ien, ring_half, met_len, n;

   rmc_line_if i_rmc_line_if ();
   rmc_line_dev #(.RAMP_STEP(16'h0002), .ENV_STEP(16'h0002)) i_rmc_line_dev (
      .clk_sys(clk_sys), .nrst(nrst), .line(i_rmc_line_if), .hook_sense(hook_sense),
      .impedance_drop_sense(impedance_drop_sense), .mode_code(mode_code),
      .loops_disabled(loops_disabled), .drivers_voltage_mode(drivers_voltage_mode),
      .line_polarity_level(line_polarity_level), .metering_envelope(metering_envelope),
      .shaped_metering_wave(shaped_metering_wave), .metering_injection(metering_injection));
   rmc_line_ctl #(.TONE_HALF_LOW(8), .TONE_HALF_HIGH(6)) i_rmc_line_ctl (
      .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .line(i_rmc_line_if));
   rmc_line_props #(.TONE_HALF_LOW(8)) i_rmc_line_props (
      .clk_sys(clk_sys), .nrst(nrst),
      .metering_tone_clock(i_rmc_line_if.metering_tone_clock),
      .metering_enable_bit(i_rmc_line_if.metering_enable_bit),
      .feed_select_bit(i_rmc_line_if.feed_select_bit),
      .polarity_bit(i_rmc_line_if.polarity_bit),
      .power_on_select(i_rmc_line_if.power_on_select),
      .loop_detect_n_o(i_rmc_line_if.loop_detect_n_o),
      .loop_detect_n_oe_n(i_rmc_line_if.loop_detect_n_oe_n),
      .loop_detect_n(i_rmc_line_if.loop_detect_n));

   // 200 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   function automatic logic pick(input int sel);
      pick = (sel == 0) ? i_rmc_line_if.metering_tone_clock :
             (sel == 1) ? i_rmc_line_if.polarity_bit : i_rmc_line_if.metering_enable_bit;
   endfunction : pick

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int g;
      g = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && g < 50)
      begin
         @(posedge clk_sys);
         g++;
      end
      q = avs_readdata;
      chk("waitrequest", 32'h0, 32'(avs_waitrequest));
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk("readdata", exp, q);
   endtask : rd_chk

   task automatic st_chk;
      rd_chk(`RMC_A_STAT, 32'(m_stat));
      chk("irq", 32'((m_stat & m_ien) != 0), 32'(irq));
   endtask : st_chk

   // cycles between two changes of a link signal
   task automatic half_len(input int sel, output int cnt);
      logic v;
      int   g;
      g = 0;
      v = pick(sel);
      while (pick(sel) === v && g < 300)
      begin
         @(posedge clk_sys);
         g++;
      end
      v = pick(sel);
      cnt = 0;
      while (pick(sel) === v && cnt < 300)
      begin
         @(posedge clk_sys);
         cnt++;
      end
   endtask : half_len

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // watchdog
   initial
   begin
      #(5 * 40000);
      bad_count++;
      give_verdict();
   end

   // main sequence
   initial
   begin
      {nrst, avs_read, avs_write, hook_sense, impedance_drop_sense} = 5'h00;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      {bad_count, checks, m_stat, m_ien} = {32'h0, 32'h0, 32'h0, 32'h0};
      lfsr_val = 8'h5f;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk("mode_code", 32'h0, 32'(mode_code));
      chk("loop_detect_n", 32'h1, 32'(i_rmc_line_if.loop_detect_n));
      rd_chk(5'h1c, 32'h0);
      rd_chk(`RMC_A_ICLR, 32'h0);
      rd_chk(`RMC_A_LIVE, 32'h8);
      wr(`RMC_A_STAT, 32'h7);
      st_chk();
      wr(`RMC_A_IEN, 32'h7);
      m_ien = 7;
      rd_chk(`RMC_A_IEN, 32'h7);
      // both tone rates
      wr(`RMC_A_CTRL, 32'h1);
      half_len(0, n);
      chk("tone_half_12k", 32'd8, 32'(n));
      wr(`RMC_A_CTRL, 32'h9);
      half_len(0, n);
      half_len(0, n);
      chk("tone_half_16k", 32'd6, 32'(n));
      // every mode with both polarities
      lfsr_val = lfsr_next(lfsr_val);
      ring_half = 2 + int'(lfsr_val % 8);
      wr(`RMC_A_RING, 32'(ring_half));
      for (logic [3:0] i = 0; i < 8; i++)
      begin
         wr(`RMC_A_CTRL, {28'h0, i});
         repeat (8) if (mode_code !== i[1:0]) @(posedge clk_sys);
         chk("mode_code", 32'(i[1:0]), 32'(mode_code));
         chk("loops_disabled", 32'(i[1:0] == 2'b11), 32'(loops_disabled));
         chk("drivers_voltage_mode", 32'(i[1:0] == 2'b11), 32'(drivers_voltage_mode));
         if (i[1:0] == 2'b10)
         begin
            repeat (1200) if (line_polarity_level !== {8{i[2]}}) @(posedge clk_sys);
            chk("line_polarity_level", 32'({8{i[2]}}), 32'(line_polarity_level));
         end
         if (i[1:0] == 2'b11)
         begin
            half_len(1, n);
            chk("ring_toggle", 32'(ring_half + 1), 32'(n));
         end
      end
      // ring trip while ringing
      impedance_drop_sense <= 1'b1;
      repeat (20) if (i_rmc_line_if.feed_select_bit !== 1'b1) @(posedge clk_sys);
      chk("feed_select_bit", 32'h1, 32'(i_rmc_line_if.feed_select_bit));
      chk("metering_enable_bit", 32'h0, 32'(i_rmc_line_if.metering_enable_bit));
      impedance_drop_sense <= 1'b0;
      rd_chk(`RMC_A_CTRL, 32'h6);
      m_stat = m_stat | 1;
      st_chk();
      wr(`RMC_A_ICLR, 32'h1);
      m_stat = m_stat & ~1;
      st_chk();
      // metering burst of random length in active mode
      lfsr_val = lfsr_next(lfsr_val);
      met_len = 5 + int'(lfsr_val % 20);
      fork
         wr(`RMC_A_METER, 32'(met_len));
         half_len(2, n);
      join
      chk("burst_length", 32'(met_len), 32'(n));
      n = int'(i_rmc_line_if.metering_tone_clock);
      @(posedge clk_sys);
      chk("shaped_metering_wave", 32'(n), 32'(shaped_metering_wave));
      chk("metering_injection", 32'h1, 32'(metering_injection));
      repeat (1000) if (metering_injection !== 1'b0) @(posedge clk_sys);
      chk("metering_injection", 32'h0, 32'(metering_injection));
      chk("metering_envelope", 32'h0, 32'(metering_envelope));
      m_stat = m_stat | 4;
      st_chk();
      wr(`RMC_A_ICLR, 32'h4);
      m_stat = m_stat & ~4;
      // burst refused outside active
      wr(`RMC_A_CTRL, 32'h1);
      wr(`RMC_A_METER, 32'd20);
      rd_chk(`RMC_A_METER, 32'h0);
      chk("metering_enable_bit", 32'h0, 32'(i_rmc_line_if.metering_enable_bit));
      // off-hook in high impedance feed, then masked and cleared
      hook_sense <= 1'b1;
      repeat (10) if (i_rmc_line_if.loop_detect_n !== 1'b0) @(posedge clk_sys);
      chk("loop_detect_n", 32'h0, 32'(i_rmc_line_if.loop_detect_n));
      repeat (4) @(posedge clk_sys);
      m_stat = m_stat | 2;
      st_chk();
      wr(`RMC_A_IEN, 32'h5);
      m_ien = 5;
      st_chk();
      wr(`RMC_A_IEN, 32'h7);
      m_ien = 7;
      hook_sense <= 1'b0;
      wr(`RMC_A_ICLR, 32'h2);
      m_stat = m_stat & ~2;
      st_chk();
      // detectors off in power down
      wr(`RMC_A_CTRL, 32'h0);
      hook_sense <= 1'b1;
      repeat (12) @(posedge clk_sys);
      chk("loop_detect_n", 32'h1, 32'(i_rmc_line_if.loop_detect_n));
      hook_sense <= 1'b0;
      give_verdict();
   end
endmodule : ring_and_metering_control_test

// file: dv/rmc_line_properties.sv
// checker for the link between the controller end and the line end
// assumes the link signals, the shared clock and the reset are wired in by name
`timescale 1ns/1ps
module rmc_line_props
#(
   parameter int TONE_HALF_LOW = 8
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic metering_tone_clock,
   input wire logic metering_enable_bit,
   input wire logic feed_select_bit,
   input wire logic polarity_bit,
   input wire logic power_on_select,
   input wire logic loop_detect_n_o,
   input wire logic loop_detect_n_oe_n,
   input wire logic loop_detect_n
);
   typedef struct packed
   {
      logic        tone_prev;
      logic [15:0] run;
   } rmc_chk_st_t;

   rmc_chk_st_t chk_reg;
   rmc_chk_st_t chk_next;
   logic        ring_sel;

   // ring code on the pins
   assign ring_sel = power_on_select & metering_enable_bit & ~feed_select_bit;

   // count cycles the tone has stood still
   always_comb
   begin
      chk_next = chk_reg;
      chk_next.tone_prev = metering_tone_clock;
      chk_next.run = (metering_tone_clock != chk_reg.tone_prev) ? 16'h0000 : chk_reg.run + 16'h0001;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         chk_reg <= '0;
      else
         chk_reg <= chk_next;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   AST_PD_PINS: assert property (!power_on_select |-> !metering_enable_bit && !feed_select_bit)
      else $error("power down with mode bits set");
   AST_PD_QUIET: assert property ((!power_on_select)[*4] |-> loop_detect_n_oe_n)
      else $error("detect driven in power down");
   AST_DET_MODE: assert property ($fell(loop_detect_n_oe_n) |-> $past(power_on_select, 2))
      else $error("detect asserted outside a live mode");
   AST_DET_DRAIN: assert property (!loop_detect_n_oe_n |-> !loop_detect_n_o)
      else $error("detect drives high");
   AST_RING_POL: assert property (ring_sel && $past(ring_sel) && $changed(polarity_bit) |=> $stable(polarity_bit))
      else $error("polarity toggled on adjacent cycles");
   AST_TRIP_EXIT: assert property (ring_sel && $fell(loop_detect_n) |-> ##[2:6] (feed_select_bit && !metering_enable_bit))
      else $error("no active mode after ring trip");
   AST_TRIP_POL: assert property ($rose(feed_select_bit) && $past(ring_sel) |-> $past(polarity_bit, 2) == $past(polarity_bit))
      else $error("polarity still toggling at ring exit");
   AST_TONE_RUN: assert property (chk_reg.run <= TONE_HALF_LOW)
      else $error("metering tone stalled");
endmodule : rmc_line_props
